// ### hw/serial_port_pkg.sv
// Purpose: constants and types of the multichannel serial port
// Assumes: APB slave, 16-bit registers in the low half
// Notes:   one clock; pins pass two flops
// Operation
// [RULE1] data, control and status are 16-bit registers on the bus
// [RULE2] hold register words move to the shifter and out on tx data
// [RULE3] rx bits go shifter, then buffer, then the read register
// [RULE4] words of 16 bits or less never touch the upper halves
// [RULE5] longer words keep their top bits in the upper halves
// [RULE6] loop-back feeds rx clock and sync from the tx pads
// [RULE7] word sizes 8, 12, 16, 20, 24 and 32 bits
// [RULE8] tx and rx run at once with own clocks and syncs
// [RULE9] two tx stages and three rx stages for gapless streams
// [RULE10] 128 channels each way, enabled in blocks of sixteen
// [RULE11] request outputs for processor and dma in each direction; the code has one event output per direction
// [RULE12] rate generator makes clock and sync, or pins supply them
// [RULE13] every clock and sync polarity is programmable
// [RULE14] optional mu-law and a-law companding
// [RULE15] 8-bit words may go least significant bit first
// [RULE16] sticky flags report underrun, overrun and stray syncs
// [RULE17] no bit-interleaved signalling mode exists
// [RULE18] frames may have two phases of own length and count
// [RULE19] exactly six serial signals to the partner
// [RULE20] rate clock is its source divided by one plus divider
// [RULE21] after reset nothing runs until software enables it
package serial_port_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_TX_LOW  = 8'h00;
    localparam logic [7:0]  OFS_TX_HIGH = 8'h04;
    localparam logic [7:0]  OFS_RX_LOW  = 8'h08;
    localparam logic [7:0]  OFS_RX_HIGH = 8'h0C;
    localparam logic [7:0]  OFS_CTRL    = 8'h10;
    localparam logic [7:0]  OFS_STATUS  = 8'h14;
    localparam logic [7:0]  OFS_RATE    = 8'h18;
    localparam logic [7:0]  OFS_CHAN    = 8'h1C;
    localparam logic [7:0]  OFS_FRAME0  = 8'h20;
    localparam logic [7:0]  OFS_FRAME1  = 8'h24;
    // writable bits
    localparam logic [15:0] CTRL_MASK   = 16'h7FFF;
    localparam logic [15:0] FRAME_MASK  = 16'h07FF;
    // status bit positions
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX_FULL  = 1;
    localparam int ST_UNDERRUN = 2;
    localparam int ST_OVERRUN  = 3;
    localparam int ST_SYNC_ERR = 4;
    localparam int ST_TX_BUSY  = 5;
    localparam int ST_RX_BUSY  = 6;
    // word length codes and bit counts
    localparam logic [2:0]  LEN_12 = 3'h1, LEN_16 = 3'h2, LEN_20 = 3'h3;
    localparam logic [2:0]  LEN_24 = 3'h4, LEN_32 = 3'h5;
    localparam logic [5:0]  BITS_8 = 6'h08, BITS_12 = 6'h0C, BITS_16 = 6'h10;
    localparam logic [5:0]  BITS_20 = 6'h14, BITS_24 = 6'h18, BITS_32 = 6'h20;
    // compander and rate codes
    localparam logic [1:0]  COMP_MU = 2'h1, COMP_ALAW = 2'h2;
    localparam logic [15:0] MU_BIAS = 16'h0021, MU_CLIP = 16'h1FFF;
    localparam logic [7:0]  ALAW_XOR = 8'h55;
    localparam logic [1:0]  SRC_TXC = 2'h1, SRC_RXC = 2'h2;
    // synchroniser slots
    localparam int SY_RXD = 0, SY_TXC = 1, SY_RXC = 2, SY_TXFS = 3, SY_RXFS = 4;

    typedef struct packed {
        logic       spare;
        logic       mc_en;
        logic [1:0] compand;
        logic       lsb_first;
        logic       rx_fs_pol;
        logic       tx_fs_pol;
        logic       rx_clk_pol;
        logic       tx_clk_pol;
        logic       loopback;
        logic       rx_clk_int;
        logic       tx_fs_int;
        logic       tx_clk_int;
        logic       rate_en;
        logic       rx_en;
        logic       tx_en;
    } ctrl_t;

    typedef struct packed {
        logic [4:0] spare;
        logic       dual;
        logic [6:0] words_m1;
        logic [2:0] len_code;
    } frame_t;

    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_ARMED = 3'b010, TX_SHIFT = 3'b100} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_SHIFT = 2'b10} rx_state_t;

    typedef struct packed {
        ctrl_t ctrl; frame_t frm0; frame_t frm1;
        logic [7:0] rate_div; logic [1:0] rate_src; logic [15:0] chan;
        logic [15:0] tx_hold_low, tx_hold_high, rx_read_low, rx_read_high;
        logic [15:0] rx_buffer_low, rx_buffer_high;
        logic tx_full, rx_read_full, rx_buf_full, underrun, overrun, sync_err;
        logic [31:0] tx_shift, rx_shift;
        logic [4:0] sync1, sync2;
        logic txc_prev, rxc_prev, rg_src_prev, rg_clk;
        logic [7:0] rg_cnt;
        tx_state_t tx_st; logic [4:0] tx_bit; logic [6:0] tx_word, tx_ch; logic tx_phase;
        rx_state_t rx_st; logic [4:0] rx_bit; logic [6:0] rx_word, rx_ch; logic rx_phase;
        logic fs_raw, txd_o, txd_oe, txc_o, txc_oe, rxc_o, rxc_oe, txfs_o, txfs_oe;
        logic tx_ev, rx_ev, pready, pslverr;
        logic [31:0] prdata;
    } state_t;
endpackage : serial_port_pkg

// ### hw/multichannel_serial_port.sv
// Purpose: multichannel buffered serial port with an APB register file
// Assumes: bit clocks below core/4, pins asynchronous
// Notes:   serial timing comes from edges seen on the core clock
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module multichannel_serial_port
    import serial_port_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        serial_rx_data_pin_in,
    output logic             serial_tx_data_pin_out,
    output logic             serial_tx_data_pin_oe_out,
    input  wire logic        tx_bit_clock_in,
    output logic             tx_bit_clock_out,
    output logic             tx_bit_clock_oe_out,
    input  wire logic        rx_bit_clock_in,
    output logic             rx_bit_clock_out,
    output logic             rx_bit_clock_oe_out,
    input  wire logic        tx_frame_sync_in,
    output logic             tx_frame_sync_out,
    output logic             tx_frame_sync_oe_out,
    input  wire logic        rx_frame_sync_in,
    output logic             tx_event_out,
    output logic             rx_event_out
);
    state_t s_q;
    state_t s_d;

    // [RULE7] bits of a length code, spare codes give 8
    function automatic logic [5:0] len_bits(input logic [2:0] code);
        case (code)
            LEN_12:  len_bits = BITS_12;
            LEN_16:  len_bits = BITS_16;
            LEN_20:  len_bits = BITS_20;
            LEN_24:  len_bits = BITS_24;
            LEN_32:  len_bits = BITS_32;
            default: len_bits = BITS_8;
        endcase
    endfunction : len_bits

    // word length of the phase
    function automatic logic [5:0] cur_len(input logic ph, input frame_t f0, input frame_t f1);
        cur_len = len_bits(ph ? f1.len_code : f0.len_code);
    endfunction : cur_len

    // last word of the phase
    function automatic logic last_word(input logic ph, input logic [6:0] wd,
                                       input frame_t f0, input frame_t f1);
        last_word = (wd == (ph ? f1.words_m1 : f0.words_m1));
    endfunction : last_word

    // channel enable, sixteen to a block
    function automatic logic chan_on(input logic mc, input logic [7:0] blk,
                                     input logic [6:0] ch);
        chan_on = !mc || blk[ch[6:4]];
    endfunction : chan_on

    // 16-bit linear sample to 8-bit law code
    function automatic logic [7:0] compress(input logic alaw, input logic [15:0] x);
        logic [15:0] mag;
        logic [2:0]  seg;
        logic [3:0]  man;
        mag = x[15] ? 16'(~x + 16'h0001) : x;
        seg = 3'h0;
        if (alaw) begin
            mag = mag >> 3;
            for (int i = 5; i <= 11; i++) begin
                if (mag[i]) seg = 3'(i - 4);
            end
            man = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
            compress = {~x[15], seg, man} ^ ALAW_XOR;
        end else begin
            mag = 16'((mag >> 2) + MU_BIAS);
            if (mag > MU_CLIP) mag = MU_CLIP;
            for (int i = 6; i <= 12; i++) begin
                if (mag[i]) seg = 3'(i - 5);
            end
            man = 4'(mag >> ({1'b0, seg} + 4'h1));
            compress = ~{x[15], seg, man};
        end
    endfunction : compress

    // 8-bit law code to 16-bit linear
    function automatic logic [15:0] expand(input logic alaw, input logic [7:0] code);
        logic [7:0]  v;
        logic [15:0] mag;
        logic        neg;
        if (alaw) begin
            v   = code ^ ALAW_XOR;
            neg = !v[7];
            mag = (v[6:4] == 3'h0) ? {11'h000, v[3:0], 1'b1}
                                   : 16'({10'h001, v[3:0], 1'b1} << (v[6:4] - 3'h1));
            mag = mag << 3;
        end else begin
            v   = ~code;
            neg = v[7];
            mag = 16'(({10'h001, v[3:0], 1'b1} << v[6:4]) - MU_BIAS);
            mag = mag << 2;
        end
        expand = neg ? 16'(~mag + 16'h0001) : mag;
    endfunction : expand

    // next state: bus, pins, rate, tx, rx, writes
    always_comb begin : next_state
        ctrl_t       c;
        logic        acc, rd, wr, wide, tick, lvl, on;
        logic        txc_pad, txfs_pad, txc_eff, rxc_eff, txfs_eff, rxfs_eff;
        logic        tx_rise, tx_fall, rx_fall, tx_lsb, rx_lsb;
        logic [5:0]  tx_len, rx_len;
        logic [7:0]  rg_next;
        logic [15:0] rdat;
        logic [31:0] w;
        logic [31:0] v;
        s_d  = s_q;
        c    = s_q.ctrl;
        // one wait state: the access acts before pready
        acc  = psel_in && penable_in && !s_q.pready;
        rd   = acc && !pwrite_in;
        wr   = acc && pwrite_in;
        wide = (len_bits(s_q.frm0.len_code) > BITS_16) ||
               (s_q.frm0.dual && len_bits(s_q.frm1.len_code) > BITS_16);
        on   = 1'b0;
        w    = 32'h0000_0000;
        v    = 32'h0000_0000;
        rdat = 16'h0000;
        s_d.pready  = acc;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;

        // [RULE1] read mux; unmapped gives pslverr
        case (paddr_in)
            OFS_TX_LOW:  rdat = s_q.tx_hold_low;
            OFS_TX_HIGH: rdat = wide ? s_q.tx_hold_high : 16'h0000;
            OFS_RX_LOW:  rdat = s_q.rx_read_low;
            OFS_RX_HIGH: rdat = wide ? s_q.rx_read_high : 16'h0000;
            OFS_CTRL:    rdat = s_q.ctrl;
            OFS_RATE:    rdat = {6'h00, s_q.rate_src, s_q.rate_div};
            OFS_CHAN:    rdat = s_q.chan;
            OFS_FRAME0:  rdat = s_q.frm0;
            OFS_FRAME1:  rdat = s_q.frm1;
            OFS_STATUS: begin
                rdat[ST_TX_EMPTY] = !s_q.tx_full;
                rdat[ST_RX_FULL]  = s_q.rx_read_full;
                rdat[ST_UNDERRUN] = s_q.underrun;
                rdat[ST_OVERRUN]  = s_q.overrun;
                rdat[ST_SYNC_ERR] = s_q.sync_err;
                rdat[ST_TX_BUSY]  = s_q.tx_st != TX_IDLE;
                rdat[ST_RX_BUSY]  = s_q.rx_st != RX_IDLE;
            end
            default:     s_d.pslverr = acc;
        endcase
        if (rd) s_d.prdata = {16'h0000, rdat};
        // [RULE3] read frees the stage
        if (rd && paddr_in == OFS_RX_LOW) s_d.rx_read_full = 1'b0;
        // clears first so a same-cycle set wins
        if (wr && paddr_in == OFS_STATUS) begin
            if (pwdata_in[ST_UNDERRUN]) s_d.underrun = 1'b0;
            if (pwdata_in[ST_OVERRUN])  s_d.overrun  = 1'b0;
            if (pwdata_in[ST_SYNC_ERR]) s_d.sync_err = 1'b0;
        end

        // pins pass two flops
        s_d.sync1 = {rx_frame_sync_in, tx_frame_sync_in, rx_bit_clock_in,
                     tx_bit_clock_in, serial_rx_data_pin_in};
        s_d.sync2 = s_q.sync1;

        // [RULE20] divide by one plus divider
        lvl     = (s_q.rate_src == SRC_TXC) ? s_q.sync2[SY_TXC] : s_q.sync2[SY_RXC];
        tick    = (s_q.rate_src == SRC_TXC || s_q.rate_src == SRC_RXC) ?
                  (lvl && !s_q.rg_src_prev) : 1'b1;
        rg_next = (s_q.rg_cnt == s_q.rate_div) ? 8'h00 : 8'(s_q.rg_cnt + 8'h01);
        s_d.rg_src_prev = lvl;
        // [RULE21] generator parked until enabled
        if (!c.rate_en) begin
            s_d.rg_cnt = 8'h00;
            s_d.rg_clk = 1'b0;
        end else if (tick) begin
            s_d.rg_cnt = rg_next;
            s_d.rg_clk = (rg_next <= (s_q.rate_div >> 1));
        end

        // [RULE12] internal or external clock and sync
        txc_pad  = c.tx_clk_int ? s_q.txc_o : s_q.sync2[SY_TXC];
        txfs_pad = c.tx_fs_int ? s_q.txfs_o : s_q.sync2[SY_TXFS];
        // [RULE13] polarity folded in at each pad
        txc_eff  = txc_pad ^ c.tx_clk_pol;
        txfs_eff = txfs_pad ^ c.tx_fs_pol;
        // [RULE6] rx taken from tx pads
        rxc_eff  = (c.loopback ? txc_pad : (c.rx_clk_int ? s_q.rxc_o : s_q.sync2[SY_RXC]))
                   ^ c.rx_clk_pol;
        rxfs_eff = (c.loopback ? txfs_pad : s_q.sync2[SY_RXFS]) ^ c.rx_fs_pol;
        // [RULE8] separate edge detectors per direction
        tx_rise  = txc_eff && !s_q.txc_prev;
        tx_fall  = !txc_eff && s_q.txc_prev;
        rx_fall  = !rxc_eff && s_q.rxc_prev;
        s_d.txc_prev = txc_eff;
        s_d.rxc_prev = rxc_eff;
        // [RULE19] clock pads driven only when internal
        s_d.txc_o   = s_q.rg_clk ^ c.tx_clk_pol;
        s_d.txc_oe  = c.tx_clk_int;
        s_d.rxc_o   = s_q.rg_clk ^ c.rx_clk_pol;
        s_d.rxc_oe  = c.rx_clk_int && !c.loopback;
        s_d.txfs_oe = c.tx_fs_int;

        // [RULE18] length follows the phase
        tx_len = cur_len(s_q.tx_phase, s_q.frm0, s_q.frm1);
        rx_len = cur_len(s_q.rx_phase, s_q.frm0, s_q.frm1);
        // [RULE15] lsb first for 8-bit only
        tx_lsb = c.lsb_first && tx_len == BITS_8;
        rx_lsb = c.lsb_first && rx_len == BITS_8;

        // external sync taken on the fall before bit zero
        if (tx_fall && s_q.tx_st == TX_IDLE && c.tx_en && !c.tx_fs_int && txfs_eff) begin
            s_d.tx_st = TX_ARMED;
        end
        if (tx_rise) begin
            s_d.fs_raw = 1'b0;
            unique case (s_q.tx_st)
                TX_IDLE: begin
                    s_d.txd_o  = 1'b0;
                    s_d.txd_oe = 1'b0;
                    // internal sync waits for data
                    if (c.tx_en && c.tx_fs_int && s_q.tx_full) begin
                        s_d.fs_raw = 1'b1;
                        s_d.tx_st  = TX_ARMED;
                    end
                end
                TX_ARMED, TX_SHIFT: begin
                    s_d.tx_st = TX_SHIFT;
                    // [RULE10] block enables gate the slot
                    on = chan_on(c.mc_en, s_q.chan[7:0], s_q.tx_ch);
                    v  = s_q.tx_shift;
                    if (s_q.tx_bit == 5'h00) begin
                        // [RULE4] short words ignore the upper half
                        w = (tx_len > BITS_16) ? {s_q.tx_hold_high, s_q.tx_hold_low}
                                               : {16'h0000, s_q.tx_hold_low};
                        // [RULE14] compress to eight bits
                        if (tx_len == BITS_8 && (c.compand == COMP_MU || c.compand == COMP_ALAW))
                            w = {24'h000000, compress(c.compand == COMP_ALAW, s_q.tx_hold_low)};
                        // [RULE16] underrun sends zeros
                        if (on && !s_q.tx_full) begin
                            s_d.underrun = 1'b1;
                            w = 32'h0000_0000;
                        end
                        // [RULE2] hold moves into the shifter
                        if (on) s_d.tx_full = 1'b0;
                        v = tx_lsb ? w : 32'(w << (BITS_32 - tx_len));
                    end
                    s_d.txd_o    = tx_lsb ? v[0] : v[31];
                    s_d.txd_oe   = on;
                    s_d.tx_shift = tx_lsb ? (v >> 1) : (v << 1);
                    s_d.tx_bit   = 5'(s_q.tx_bit + 5'h01);
                    if ({1'b0, s_q.tx_bit} == tx_len - 6'h01) begin
                        s_d.tx_bit = 5'h00;
                        s_d.tx_ch  = 7'(s_q.tx_ch + 7'h01);
                        if (!last_word(s_q.tx_phase, s_q.tx_word, s_q.frm0, s_q.frm1)) begin
                            s_d.tx_word = 7'(s_q.tx_word + 7'h01);
                        end else if (s_q.frm0.dual && !s_q.tx_phase) begin
                            s_d.tx_phase = 1'b1;
                            s_d.tx_word  = 7'h00;
                        end else begin
                            s_d.tx_st = TX_IDLE;
                        end
                    end
                end
            endcase
            if (s_q.tx_st == TX_IDLE) begin
                s_d.tx_bit   = 5'h00;
                s_d.tx_word  = 7'h00;
                s_d.tx_ch    = 7'h00;
                s_d.tx_phase = 1'b0;
            end
        end
        s_d.txfs_o = s_d.fs_raw ^ c.tx_fs_pol;

        // [RULE9] read stage refills from the buffer
        if (s_d.rx_buf_full && !s_d.rx_read_full) begin
            s_d.rx_read_low  = s_q.rx_buffer_low;
            if (wide) s_d.rx_read_high = s_q.rx_buffer_high;
            s_d.rx_read_full = 1'b1;
            s_d.rx_buf_full  = 1'b0;
        end
        if (rx_fall && c.rx_en) begin
            if (rxfs_eff) begin
                // sync mid-frame restarts and is flagged
                if (s_q.rx_st == RX_SHIFT) s_d.sync_err = 1'b1;
                s_d.rx_st    = RX_SHIFT;
                s_d.rx_bit   = 5'h00;
                s_d.rx_word  = 7'h00;
                s_d.rx_ch    = 7'h00;
                s_d.rx_phase = 1'b0;
            end else if (s_q.rx_st == RX_SHIFT) begin
                // [RULE3] sample into the shifter
                v = rx_lsb ? {s_q.sync2[SY_RXD], s_q.rx_shift[31:1]}
                           : {s_q.rx_shift[30:0], s_q.sync2[SY_RXD]};
                s_d.rx_shift = v;
                s_d.rx_bit   = 5'(s_q.rx_bit + 5'h01);
                if ({1'b0, s_q.rx_bit} == rx_len - 6'h01) begin
                    w = rx_lsb ? {24'h000000, v[31:24]}
                               : (v & (32'hFFFF_FFFF >> (BITS_32 - rx_len)));
                    // [RULE14] expand to sixteen bits
                    if (rx_len == BITS_8 && (c.compand == COMP_MU || c.compand == COMP_ALAW))
                        w = {16'h0000, expand(c.compand == COMP_ALAW, w[7:0])};
                    if (chan_on(c.mc_en, s_q.chan[15:8], s_q.rx_ch)) begin
                        // [RULE16] overrun drops the new word
                        if (s_d.rx_buf_full) begin
                            s_d.overrun = 1'b1;
                        end else begin
                            s_d.rx_buffer_low = w[15:0];
                            // [RULE5] top bits in upper half
                            if (rx_len > BITS_16) s_d.rx_buffer_high = w[31:16];
                            s_d.rx_buf_full = 1'b1;
                        end
                    end
                    s_d.rx_bit = 5'h00;
                    s_d.rx_ch  = 7'(s_q.rx_ch + 7'h01);
                    if (!last_word(s_q.rx_phase, s_q.rx_word, s_q.frm0, s_q.frm1)) begin
                        s_d.rx_word = 7'(s_q.rx_word + 7'h01);
                    end else if (s_q.frm0.dual && !s_q.rx_phase) begin
                        s_d.rx_phase = 1'b1;
                        s_d.rx_word  = 7'h00;
                    end else begin
                        s_d.rx_st = RX_IDLE;
                    end
                end
            end
        end
        if (!c.rx_en) s_d.rx_st = RX_IDLE;

        // writes last: they beat a same-cycle consume
        if (wr) begin
            case (paddr_in)
                OFS_TX_LOW: begin
                    s_d.tx_hold_low = pwdata_in[15:0];
                    s_d.tx_full     = 1'b1;
                end
                // [RULE5] upper half only for long words
                OFS_TX_HIGH: if (wide) s_d.tx_hold_high = pwdata_in[15:0];
                // [RULE17] spare bit stays zero
                OFS_CTRL:    s_d.ctrl = ctrl_t'(pwdata_in[15:0] & CTRL_MASK);
                OFS_RATE: begin
                    s_d.rate_div = pwdata_in[7:0];
                    s_d.rate_src = pwdata_in[9:8];
                end
                OFS_CHAN:    s_d.chan = pwdata_in[15:0];
                OFS_FRAME0:  s_d.frm0 = frame_t'(pwdata_in[15:0] & FRAME_MASK);
                OFS_FRAME1:  s_d.frm1 = frame_t'(pwdata_in[15:0] & FRAME_MASK);
                default: ;
            endcase
        end
        // [RULE11] request levels
        s_d.tx_ev = c.tx_en && !s_d.tx_full;
        s_d.rx_ev = s_d.rx_read_full;
    end

    // [RULE21] reset leaves every path idle
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_q       <= '0;
            s_q.tx_st <= TX_IDLE;
            s_q.rx_st <= RX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs from the state register
    assign prdata_out                = s_q.prdata;
    assign pready_out                = s_q.pready;
    assign pslverr_out               = s_q.pslverr;
    assign serial_tx_data_pin_out    = s_q.txd_o;
    assign serial_tx_data_pin_oe_out = s_q.txd_oe;
    assign tx_bit_clock_out          = s_q.txc_o;
    assign tx_bit_clock_oe_out       = s_q.txc_oe;
    assign rx_bit_clock_out          = s_q.rxc_o;
    assign rx_bit_clock_oe_out       = s_q.rxc_oe;
    assign tx_frame_sync_out         = s_q.txfs_o;
    assign tx_frame_sync_oe_out      = s_q.txfs_oe;
    assign tx_event_out              = s_q.tx_ev;
    assign rx_event_out              = s_q.rx_ev;
endmodule : multichannel_serial_port

// ### verif/codec_echo_model.sv
// Purpose: far side that echoes tx data onto rx data
// Assumes: loop-back feeds rx clock and sync
// Notes:   a released data line shows the inverse of its last value; released clock and sync pads read low
`timescale 1ns/1ps
module codec_echo_model (
    input  wire logic clk_in, txd_in, txd_oe_in, txc_in, txc_oe_in, fs_in, fs_oe_in,
    output logic      rxd_out, txc_pad_out, fs_pad_out, rxc_out, rxfs_out
);
    logic last_q = 1'h0;
    always_ff @(posedge clk_in) if (txd_oe_in) last_q <= txd_in;
    assign rxd_out     = txd_oe_in ? txd_in : ~last_q;
    assign txc_pad_out = txc_oe_in & txc_in; // low when undriven
    assign fs_pad_out  = fs_oe_in & fs_in;
    assign rxc_out     = 1'h0; // idle, loop-back used
    assign rxfs_out    = 1'h0;
endmodule : codec_echo_model

// ### verif/serial_port_sva.sv
// Purpose: bus and start-up checks
// Assumes: one clock, synchronous active low reset
// Notes:   bound into every instance of the port
`timescale 1ns/1ps
module serial_port_sva (
    input wire logic        core_clk_in, rst_n_in, psel_in, penable_in, pready_out, pslverr_out,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        serial_tx_data_pin_oe_out, tx_event_out, rx_event_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // first access cycle
    wire logic acc = psel_in && penable_in && !pready_out;
    a_one_wait: assert property (acc |=> pready_out) else $error("late answer");
    a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("long ready");
    a_ready_cause: assert property (pready_out |-> $past(acc)) else $error("stray ready");
    a_data_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("data");
    a_half_word: assert property (prdata_out[31:16] == 16'h0) else $error("wide data");
    a_err_map: assert property (acc && paddr_in > 8'h24 |=> pslverr_out) else $error("no err");
    a_err_only: assert property (pslverr_out |-> pready_out) else $error("lone err");
    a_quiet_start: assert property ($rose(rst_n_in) |-> !serial_tx_data_pin_oe_out && !tx_event_out) else $error("busy");
    c_err: cover property (pslverr_out);
    c_rx: cover property (rx_event_out);
    c_tx: cover property (tx_event_out);
endmodule : serial_port_sva
bind multichannel_serial_port serial_port_sva serial_port_sva_inst (.*);

// ### verif/multichannel_serial_port_test.sv
// Purpose: register and loop-back test
// Assumes: answers come in request order
// Notes:   rate clock is core/8, above the pin delay
`timescale 1ns/1ps
module multichannel_serial_port_test;
    import serial_port_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, rxd, txd, txd_oe;
    logic txc, txc_oe, txc_pad, rxc, fs, fs_oe, fs_pad, rxfs, tx_ev, rx_ev;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, lf = 32'h04FE, m;
    logic [33:0] exp_q[$], e_m;
    int fails = 0, cmp_count = 0, nb[6] = '{8, 12, 16, 20, 24, 32};
    always #50 clk = ~clk;
    multichannel_serial_port multichannel_serial_port_inst (.core_clk_in(clk), .rst_n_in(rst_n),
        .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .serial_rx_data_pin_in(rxd), .serial_tx_data_pin_out(txd), .serial_tx_data_pin_oe_out(txd_oe),
        .tx_bit_clock_in(txc_pad), .tx_bit_clock_out(txc), .tx_bit_clock_oe_out(txc_oe),
        .rx_bit_clock_in(rxc), .rx_bit_clock_out(), .rx_bit_clock_oe_out(), .tx_frame_sync_in(fs_pad),
        .tx_frame_sync_out(fs), .tx_frame_sync_oe_out(fs_oe), .rx_frame_sync_in(rxfs),
        .tx_event_out(tx_ev), .rx_event_out(rx_ev));
    codec_echo_model codec_echo_model_inst (.clk_in(clk), .txd_in(txd), .txd_oe_in(txd_oe),
        .txc_in(txc), .txc_oe_in(txc_oe), .fs_in(fs), .fs_oe_in(fs_oe), .rxd_out(rxd),
        .txc_pad_out(txc_pad), .fs_pad_out(fs_pad), .rxc_out(rxc), .rxfs_out(rxfs));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    // apb transfer; e = {check data, error, data}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        int n = 0;
        psel <= 1'h1; pen <= 1'h0; pwr <= w; paddr <= a; pwdata <= d;
        exp_q.push_back(e);
        @(posedge clk) pen <= 1'h1;
        do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin fails++; stop_test(); end
        psel <= 1'h0; pen <= 1'h0;
        @(posedge clk);
    endtask : apb
    // each answer meets the oldest note
    always @(posedge clk) if (pready === 1'h1) begin
        e_m = exp_q.pop_front();
        check({pslverr, e_m[33] ? prdata : 32'h0}, e_m[32:0]);
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h0, OFS_CTRL, 32'h0, {2'h2, 32'h0});
        apb(1'h0, OFS_STATUS, 32'h0, {2'h2, 32'h1});
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            apb(1'h1, OFS_CHAN, lf, 34'h0);
            apb(1'h0, OFS_CHAN, 32'h0, {2'h2, 16'h0, lf[15:0]});
            apb(1'h1, OFS_FRAME1, lf, 34'h0);
            apb(1'h0, OFS_FRAME1, 32'h0, {2'h2, 16'h0, lf[15:0] & FRAME_MASK});
        end
        apb(1'h0, 8'h28, 32'h0, {2'h3, 32'h0});
        apb(1'h1, 8'h3C, lf, {2'h1, 32'h0});
        // loop-back, internal clock and sync; divider 7 clears the pin delay
        apb(1'h1, OFS_RATE, 32'h7, 34'h0);
        apb(1'h1, OFS_CTRL, 32'h5F, 34'h0);
        for (int c = 0; c < 6; c++) begin
            automatic int n = 0;
            lf = lfsr(lf);
            m = 32'hFFFFFFFF >> (32 - nb[c]);
            apb(1'h1, OFS_FRAME0, 32'(c), 34'h0);
            apb(1'h1, OFS_TX_HIGH, {16'h0, lf[31:16]}, 34'h0);
            apb(1'h1, OFS_TX_LOW, {16'h0, lf[15:0]}, 34'h0);
            while (rx_ev !== 1'h1 && n < 900) begin @(posedge clk); n++; end
            if (n >= 900) begin fails++; stop_test(); end
            apb(1'h0, OFS_RX_HIGH, 32'h0, {2'h2, 16'h0, lf[31:16] & m[31:16]});
            apb(1'h0, OFS_RX_LOW, 32'h0, {2'h2, 16'h0, lf[15:0] & m[15:0]});
        end
        stop_test();
    end
endmodule : multichannel_serial_port_test
